//--- logic/sac_top.sv
`timescale 1ns/1ps
// Operation
// R1: First byte after start is address byte
// R2: Address derived from three four-state straps
// R3: Strap decode follows fixed address table
// R4: Address LSB selects direction for transfer
// R5: Second written byte loads control register
// R6: Upper nibble config, lower nibble channel
// R7: Auto-increment advances channel per conversion
// R8: Master sets output enable with auto-increment
// R9: Output enable keeps oscillator running
// R10: Missing channel uses highest, wraps to zero
// R11: Reset clears control, oscillator, output
// R12: Master sets bits 7,3 only slow
// R13: Bits 7 and 3 halve conversion clock
// R14: Bit7 low, bit3 high shows osc/4
// R15: Start runs oscillator, mismatch stops it; code keeps it running on a mismatch while output enable is set
// R16: Stop halts oscillator unless output enabled
// R17: Acknowledge each received byte when addressed
// R18: Third written byte loads DAC data
// R19: Field layout bit6 aoe, 5:4 cfg
// R20: Compare seven address bits, ignore direction
module sac_top
  import sac_pkg::*;
#(
  parameter int OSC_DIV = 8
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_b,
  input  wire logic       addr_strap_0,
  input  wire logic       addr_strap_1,
  input  wire logic       addr_strap_2,
  input  wire logic [7:0] adc_data,
  output logic [7:0]      function_control,
  output logic [7:0]      dac_data,
  output logic            dac_load,
  output logic            analog_output_pin_en,
  output logic [1:0]      adc_channel,
  output logic            conv_start,
  output logic            osc_run,
  output logic            conv_half_rate,
  output logic            osc_tick,
  output logic            osc_observe_pin
);

  logic          rst_meta_q;
  logic          rst_n;
  logic [4:0]    s1_q, s2_q, s3_q, filt_q, prev_q;
  logic [2:0]    warm_q;
  logic [2:0]    dscl_q, dsda_q;
  logic [6:0]    own_addr_q;
  sac_state_type state_q;
  logic [3:0]    bit_cnt_q;
  logic [7:0]    shift_q;
  logic          rd_q;
  logic [1:0]    idx_q;
  logic          sda_oe_b_q;
  logic [7:0]    ctrl_q;
  logic [1:0]    chan_q;
  logic [7:0]    dac_q;
  logic          dac_load_q, conv_q, run_q;
  logic          aoe_q, half_q, obs_en_q;
  logic          tick_q, obs_q;
  logic          scl_f, sda_f, scl_p, sda_p;
  logic          scl_rise, scl_fall, start_det, stop_det, stable;
  logic          byte_end, addr_hit, wr_byte;
  logic [5:0]    ties;

  sac_osc_if oif ();

  // Release of reset is synchronised; assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Pin order {sda, scl, strap2, strap1, strap0}
  for (genvar i = 0; i < 5; i++) begin : g_pin
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        s1_q[i]   <= PIN_RST[i];
        s2_q[i]   <= PIN_RST[i];
        s3_q[i]   <= PIN_RST[i];
        filt_q[i] <= PIN_RST[i];
      end else begin
        s1_q[i] <= i == 4 ? sda_in : i == 3 ? scl_in :
                   i == 2 ? addr_strap_2 : i == 1 ? addr_strap_1 : addr_strap_0;
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= PIN_RST;
      warm_q <= 3'h0;
    end else begin
      prev_q <= filt_q;
      if (warm_q != WARM_CYC) begin
        warm_q <= warm_q + 3'h1;
      end
    end
  end

  assign scl_f     = filt_q[3];
  assign sda_f     = filt_q[4];
  assign scl_p     = prev_q[3];
  assign sda_p     = prev_q[4];
  assign scl_rise  = scl_f & ~scl_p;
  assign scl_fall  = ~scl_f & scl_p;
  assign start_det = scl_f & scl_p & ~sda_f & sda_p;
  assign stop_det  = scl_f & scl_p & sda_f & ~sda_p;
  // Skew between synchronisers could fake a mismatch; only judge settled pins
  assign stable    = (filt_q == prev_q) && (warm_q == WARM_CYC);

  function automatic logic [1:0] tie_of(input logic ds, input logic dd, input logic lvl);
    if (ds && dd) begin
      tie_of = lvl ? TIE_VDD : TIE_VSS;
    end else if (dd) begin
      tie_of = TIE_SCL;
    end else if (ds) begin
      tie_of = TIE_SDA;
    end else begin
      tie_of = TIE_VDD;
    end
  endfunction

  function automatic logic [6:0] addr_of(input logic [5:0] t);
    addr_of = ADDR_BASE;
    for (int k = 0; k < 64; k++) begin
      if (STRAP_MAP[k] == t) begin
        addr_of = ADDR_BASE + 7'(k);
      end
    end
  endfunction

  // Sticky "seen differing from SCL/SDA" per strap
  for (genvar j = 0; j < 3; j++) begin : g_strap
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        dscl_q[j] <= 1'b0;
        dsda_q[j] <= 1'b0;
      end else if (stable) begin
        dscl_q[j] <= dscl_q[j] | (filt_q[j] != scl_f); // R2
        dsda_q[j] <= dsda_q[j] | (filt_q[j] != sda_f); // R2
      end
    end
    assign ties[2*j+1:2*j] = tie_of(dscl_q[j], dsda_q[j], filt_q[j]);
  end

  // Every tie is resolved by the first SCL fall after a start
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      own_addr_q <= ADDR_BASE;
    end else begin
      own_addr_q <= addr_of(ties); // R3
    end
  end

  assign byte_end = scl_fall && (bit_cnt_q == BITS_BYTE);
  assign addr_hit = shift_q[7:1] == own_addr_q; // R20
  assign wr_byte  = byte_end && (state_q == ST_RX);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      rd_q       <= 1'b0;
      sda_oe_b_q <= 1'b1;
    end else if (start_det) begin
      state_q    <= ST_ADDR; // R1
      bit_cnt_q  <= 4'h0;
      sda_oe_b_q <= 1'b1;
    end else if (stop_det) begin
      state_q    <= ST_IDLE;
      sda_oe_b_q <= 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          sda_oe_b_q <= 1'b1;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_f};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (byte_end) begin
            if (state_q == ST_RX || addr_hit) begin // R1
              state_q    <= state_q == ST_RX ? ST_ACK_W : ST_ACK_A;
              sda_oe_b_q <= 1'b0; // R17
            end else begin
              state_q <= ST_IDLE;
            end
            if (state_q == ST_ADDR) begin
              rd_q <= shift_q[0]; // R4
            end
          end
        end
        ST_ACK_A, ST_ACK_W: begin
          if (scl_fall) begin
            bit_cnt_q <= rd_q ? 4'h1 : 4'h0;
            if (rd_q) begin // R4
              state_q    <= ST_TX;
              shift_q    <= {adc_data[6:0], 1'b0};
              sda_oe_b_q <= adc_data[7];
            end else begin
              state_q    <= ST_RX;
              sda_oe_b_q <= 1'b1;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == BITS_BYTE) begin
              state_q    <= ST_ACK_R;
              sda_oe_b_q <= 1'b1;
            end else begin
              sda_oe_b_q <= shift_q[7];
              shift_q    <= {shift_q[6:0], 1'b0};
              bit_cnt_q  <= bit_cnt_q + 4'h1;
            end
          end
        end
        ST_ACK_R: begin
          if (scl_rise && sda_f) begin
            state_q <= ST_IDLE;
          end else if (scl_fall) begin
            state_q    <= ST_TX;
            shift_q    <= {adc_data[6:0], 1'b0};
            sda_oe_b_q <= adc_data[7];
            bit_cnt_q  <= 4'h1;
          end
        end
      endcase
    end
  end

  // Conversion triggered at trailing edge of each read acknowledge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_q <= 1'b0;
    end else begin
      conv_q <= scl_fall && ((state_q == ST_ACK_A && rd_q) || state_q == ST_ACK_R);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= IDX_CTRL;
    end else if (byte_end && state_q == ST_ADDR) begin
      idx_q <= IDX_CTRL;
    end else if (wr_byte && idx_q != IDX_DAC) begin
      idx_q <= idx_q + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST; // R11
    end else if (wr_byte && idx_q == IDX_CTRL) begin
      ctrl_q <= shift_q; // R5 R6 R19
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dac_q      <= 8'h00;
      dac_load_q <= 1'b0;
    end else begin
      dac_load_q <= wr_byte && idx_q == IDX_DAC; // R18
      if (wr_byte && idx_q == IDX_DAC) begin
        dac_q <= shift_q; // R18
      end
    end
  end

  function automatic logic [1:0] top_ch(input logic [1:0] cfg);
    unique case (cfg)
      2'h0: top_ch = 2'h3;
      2'h1: top_ch = 2'h2;
      2'h2: top_ch = 2'h2;
      2'h3: top_ch = 2'h1;
    endcase
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chan_q <= 2'h0;
    end else if (wr_byte && idx_q == IDX_CTRL) begin
      chan_q <= shift_q[CH_HI:CH_LO] > top_ch(shift_q[CFG_HI:CFG_LO]) ?
                top_ch(shift_q[CFG_HI:CFG_LO]) : shift_q[CH_HI:CH_LO]; // R10 R6
    end else if (conv_q && ctrl_q[B_AINC]) begin
      chan_q <= chan_q == top_ch(ctrl_q[CFG_HI:CFG_LO]) ? 2'h0 : chan_q + 2'h1; // R7 R10
    end
  end

  // Output enable also pins the oscillator on, avoiding start-up delay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0; // R11
    end else if (start_det) begin
      run_q <= 1'b1; // R15
    end else if (stop_det) begin
      run_q <= ctrl_q[B_AOE]; // R16
    end else if (byte_end && state_q == ST_ADDR && !addr_hit) begin
      run_q <= ctrl_q[B_AOE]; // R15
    end else if (ctrl_q[B_AOE]) begin
      run_q <= 1'b1; // R9
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aoe_q    <= 1'b0;
      half_q   <= 1'b0;
      obs_en_q <= 1'b0;
    end else begin
      aoe_q    <= ctrl_q[B_AOE]; // R11
      half_q   <= ctrl_q[B_OSC_HI] & ctrl_q[B_OSC_LO]; // R13
      obs_en_q <= ~ctrl_q[B_OSC_HI] & ctrl_q[B_OSC_LO]; // R14
    end
  end

  assign oif.run    = run_q;
  assign oif.half   = half_q;
  assign oif.obs_en = obs_en_q;
  assign tick_q     = oif.tick;
  assign obs_q      = oif.obs;

  sac_osc #(.OSC_DIV(OSC_DIV)) u_osc (
    .clock (clock),
    .rst_n (rst_n),
    .oif   (oif.osc)
  );

  assign sda_out              = 1'b0;
  assign sda_oe_b             = sda_oe_b_q;
  assign function_control     = ctrl_q;
  assign dac_data             = dac_q;
  assign dac_load             = dac_load_q;
  assign analog_output_pin_en = aoe_q;
  assign adc_channel          = chan_q;
  assign conv_start           = conv_q;
  assign osc_run              = run_q;
  assign conv_half_rate       = half_q;
  assign osc_tick             = tick_q;
  assign osc_observe_pin      = obs_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_addr_miss;
    byte_end && state_q == ST_ADDR && !addr_hit;
  endsequence

  sequence s_read_ack;
    scl_fall && state_q == ST_ACK_A && rd_q;
  endsequence

  a_ack_drive: assert property ((state_q == ST_ACK_W) |-> !sda_oe_b_q) // R17
    else $error("write acknowledge not driven");
  a_addr_gate: assert property (s_addr_miss |=> state_q == ST_IDLE && sda_oe_b_q) // R1
    else $error("mismatched address answered");
  a_ctrl_load: assert property (wr_byte && idx_q == IDX_CTRL |=> ctrl_q == $past(shift_q)) // R5
    else $error("control byte not stored");
  a_dac_load: assert property (wr_byte && idx_q == IDX_DAC |=> dac_load_q && dac_q == $past(shift_q)) // R18
    else $error("dac byte not stored");
  a_read_conv: assert property (s_read_ack |=> conv_q ##1 !conv_q) // R4
    else $error("read conversion pulse wrong");
  a_osc_hold: assert property (ctrl_q[B_AOE] && !start_det |=> run_q) // R9
    else $error("oscillator stopped while output enabled");
  a_start_run: assert property (start_det |=> run_q) // R15
    else $error("oscillator not started");
  a_stop_halt: assert property (stop_det && !ctrl_q[B_AOE] |=> !run_q) // R16
    else $error("oscillator not stopped at stop");
  a_chan_range: assert property (chan_q <= top_ch(ctrl_q[CFG_HI:CFG_LO]) || $changed(ctrl_q)) // R10
    else $error("channel outside configuration");
  a_chan_step: assert property (conv_q && ctrl_q[B_AINC] && !wr_byte
      |=> chan_q == ($past(chan_q) == top_ch(ctrl_q[CFG_HI:CFG_LO]) ? 2'h0 : $past(chan_q) + 2'h1)) // R7
    else $error("auto-increment step wrong");
  a_half_rate: assert property ($changed(ctrl_q) |-> ##1 half_q == (ctrl_q[B_OSC_HI] & ctrl_q[B_OSC_LO])) // R13
    else $error("half rate not following control");

endmodule

//--- logic/sac_pkg.sv
package sac_pkg;

  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam int         B_OSC_HI  = 7;
  localparam int         B_AOE     = 6;
  localparam int         CFG_HI    = 5;
  localparam int         CFG_LO    = 4;
  localparam int         B_OSC_LO  = 3;
  localparam int         B_AINC    = 2;
  localparam int         CH_HI     = 1;
  localparam int         CH_LO     = 0;

  localparam logic [6:0] ADDR_BASE = 7'h20;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [1:0] IDX_CTRL  = 2'h0;
  localparam logic [1:0] IDX_DAC   = 2'h1;
  localparam logic [2:0] WARM_CYC  = 3'h7;
  localparam logic [4:0] PIN_RST   = 5'h18;

  // Strap tie codes
  localparam logic [1:0] TIE_VSS   = 2'h0;
  localparam logic [1:0] TIE_VDD   = 2'h1;
  localparam logic [1:0] TIE_SCL   = 2'h2;
  localparam logic [1:0] TIE_SDA   = 2'h3;

  // Tie triple {strap2,strap1,strap0} per address, address = ADDR_BASE + index
  localparam logic [5:0] STRAP_MAP [64] = '{
    6'h03, 6'h07, 6'h13, 6'h17, 6'h0C, 6'h0D, 6'h1C, 6'h1D,
    6'h30, 6'h31, 6'h34, 6'h35, 6'h0F, 6'h1F, 6'h33, 6'h37,
    6'h3C, 6'h3D, 6'h3F, 6'h2A, 6'h02, 6'h06, 6'h12, 6'h16,
    6'h08, 6'h09, 6'h18, 6'h19, 6'h20, 6'h21, 6'h24, 6'h25,
    6'h0A, 6'h1A, 6'h22, 6'h26, 6'h28, 6'h29, 6'h0B, 6'h1B,
    6'h00, 6'h01, 6'h04, 6'h05, 6'h10, 6'h11, 6'h14, 6'h15,
    6'h0E, 6'h1E, 6'h2C, 6'h2D, 6'h38, 6'h39, 6'h32, 6'h36,
    6'h23, 6'h27, 6'h3A, 6'h2E, 6'h2B, 6'h2F, 6'h3B, 6'h3E
  };

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_A, ST_RX, ST_ACK_W, ST_TX, ST_ACK_R
  } sac_state_type;

endpackage

//--- logic/sac_osc_if.sv
`timescale 1ns/1ps
interface sac_osc_if;
  logic run;
  logic half;
  logic obs_en;
  logic tick;
  logic obs;
  modport ctl (output run, output half, output obs_en, input tick, input obs);
  modport osc (input run, input half, input obs_en, output tick, output obs);
endinterface

//--- logic/sac_osc.sv
`timescale 1ns/1ps
module sac_osc
  import sac_pkg::*;
#(
  parameter int OSC_DIV = 8
) (
  input  wire logic clock,
  input  wire logic rst_n,
  sac_osc_if.osc    oif
);

  localparam int CW = $clog2(2 * OSC_DIV);
  localparam logic [CW-1:0] LIM_FULL = CW'(OSC_DIV - 1);
  localparam logic [CW-1:0] LIM_HALF = CW'(2 * OSC_DIV - 1);

  logic [CW-1:0] cnt_q;
  logic [1:0]    div4_q;
  logic          tick_q;
  logic          obs_q;
  logic [CW-1:0] lim;

  assign lim = oif.half ? LIM_HALF : LIM_FULL; // R13

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
      div4_q <= 2'h0;
    end else if (!oif.run) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (cnt_q == lim);
      cnt_q  <= (cnt_q == lim) ? '0 : cnt_q + 1'b1;
      if (cnt_q == lim) begin
        div4_q <= div4_q + 2'h1;
      end
    end
  end

  // Observe pin idles low unless enabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      obs_q <= 1'b0;
    end else begin
      obs_q <= oif.obs_en & div4_q[1]; // R14
    end
  end

  assign oif.tick = tick_q;
  assign oif.obs  = obs_q;

  a_obs_low: assert property (@(posedge clock) disable iff (!rst_n) !oif.obs_en |=> !obs_q) // R14
    else $error("observe pin not low while disabled");

endmodule

//--- dv/sac_i2c_master.sv
`timescale 1ns/1ps
module sac_i2c_master (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl_o,
  output logic      sda_o
);
  // Quarter of an SCL period in clocks; raised for slow-bus writes
  int qtr = 4;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Works as repeated start too: SDA rises while SCL is low first
  task automatic start();
    sda_o <= 1'b1;
    wt(qtr);
    scl_o <= 1'b1;
    wt(qtr);
    sda_o <= 1'b0;
    wt(qtr);
    scl_o <= 1'b0;
    wt(qtr);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    wt(qtr);
    scl_o <= 1'b1;
    wt(qtr);
    sda_o <= 1'b1;
    wt(qtr);
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_o <= b;
    wt(qtr);
    scl_o <= 1'b1;
    wt(qtr);
    r = sda;
    wt(qtr);
    scl_o <= 1'b0;
    wt(qtr);
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(~mack, r);
  endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
  import sac_pkg::*;
  typedef struct packed {
    logic [5:0] t;
    logic [7:0] a;
    logic [7:0] c;
    logic [7:0] d;
    logic [1:0] ch;
  } sac_row_type;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  adc_data = 8'h00;
  logic [5:0]  ties = 6'h00;
  logic [7:0]  fc, dac_data, rb;
  logic        sda_out, sda_oe_b, dac_load, aope, conv_start, osc_run, half, tick, obs, obs_q;
  logic [1:0]  chan;
  logic        scl, sda_m;
  logic [2:0]  straps, acks;
  wire         sda = sda_m & (sda_oe_b | sda_out);
  int          n_errors = 0;
  int          samples_checked = 0;
  int          n_load = 0, n_conv = 0, n_tick = 0, n_rise = 0, k0, k1;
  sac_row_type rows [5] = '{
    '{6'h00, 8'h90, 8'h45, 8'h5A, 2'h1},
    '{6'h15, 8'h9E, 8'h12, 8'hA5, 2'h2},
    '{6'h03, 8'h40, 8'h23, 8'hFF, 2'h2},
    '{6'h2A, 8'h66, 8'h33, 8'h00, 2'h1},
    '{6'h3E, 8'hBE, 8'h01, 8'h80, 2'h1}
  };

  always #5 clock = ~clock;

  function automatic logic lvl(input logic [1:0] c, input logic s, input logic d);
    return (c == TIE_VSS) ? 1'b0 : (c == TIE_VDD) ? 1'b1 : (c == TIE_SCL) ? s : d;
  endfunction
  for (genvar g = 0; g < 3; g++) begin : g_strap
    assign straps[g] = lvl(ties[2*g+:2], scl, sda);
  end

  sac_i2c_master mst (.clock(clock), .sda(sda), .scl_o(scl), .sda_o(sda_m));

  sac_top #(.OSC_DIV(4)) DUT (
    .clock(clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_b(sda_oe_b), .addr_strap_0(straps[0]), .addr_strap_1(straps[1]),
    .addr_strap_2(straps[2]), .adc_data(adc_data), .function_control(fc),
    .dac_data(dac_data), .dac_load(dac_load), .analog_output_pin_en(aope),
    .adc_channel(chan), .conv_start(conv_start), .osc_run(osc_run),
    .conv_half_rate(half), .osc_tick(tick), .osc_observe_pin(obs)
  );

  always @(posedge clock) begin
    n_load += (dac_load === 1'b1);
    n_conv += (conv_start === 1'b1);
    n_tick += (tick === 1'b1);
    n_rise += (obs === 1'b1 && obs_q !== 1'b1);
    obs_q <= obs;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr3(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
    mst.start();
    mst.wr(a, acks[2]);
    mst.wr(c, acks[1]);
    mst.wr(d, acks[0]);
    mst.stop();
    mst.wt(8);
  endtask

  task automatic rdn(input logic [7:0] a, input int n);
    mst.start();
    mst.wr(a | 8'h01, acks[2]);
    for (int i = 1; i <= n; i++) mst.rd(i < n, rb);
    mst.stop();
    mst.wt(8);
  endtask

  // Counts over a fixed span; phase of the divider is unknown, hence the window
  task automatic span(input int tk, input int rs);
    k0 = n_tick;
    k1 = n_rise;
    mst.wt(160);
    chk({7'h00, (n_tick - k0) inside {[tk-1:tk+1]}}, 8'h01);
    chk({7'h00, (n_rise - k1) inside {[rs-1:rs+1]}}, 8'h01);
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    mst.wt(2);
    chk(fc, 8'h00);
    chk({aope, osc_run, obs, sda_oe_b}, 8'h01);
    mst.wt(30);
    $display("test reset done");
    // Strap classes are sticky; a new strapping needs a fresh reset
    foreach (rows[i]) begin
      rst_b <= 1'b0;
      ties  <= rows[i].t;
      mst.wt(2);
      rst_b <= 1'b1;
      mst.wt(30);
      mst.start();
      mst.stop();
      k0 = n_load;
      wr3(rows[i].a, rows[i].c, rows[i].d);
      chk({5'h00, acks}, 8'h07);
      chk(fc, rows[i].c);
      chk(dac_data, rows[i].d);
      chk(n_load - k0, 8'h01);
      chk(chan, rows[i].ch);
      chk(aope, rows[i].c[6]);
      wr3(rows[i].a ^ 8'h02, 8'hFF, 8'h11);
      chk({5'h00, acks}, 8'h00);
      chk(fc, rows[i].c);
      chk(osc_run, rows[i].c[6]);
      $display("test row %0d done", i);
    end
    wr3(8'hBE, 8'h44, 8'h00);
    chk(chan, 2'h0);
    adc_data <= 8'hC3;
    k0 = n_conv;
    rdn(8'hBE, 2);
    chk(acks[2], 1'b1);
    chk(rb, 8'hC3);
    chk(n_conv - k0, 8'h02);
    chk(chan, 2'h2);
    chk(osc_run, 1'b1);
    wr3(8'hBE, 8'h76, 8'h00);
    chk(chan, 2'h1);
    adc_data <= 8'h3C;
    rdn(8'hBE, 1);
    chk(rb, 8'h3C);
    chk(chan, 2'h0);
    $display("test autoinc done");
    wr3(8'hBE, 8'h00, 8'h00);
    chk({aope, osc_run}, 8'h00);
    wr3(8'hBE, 8'h48, 8'h00);
    chk(half, 1'b0);
    span(40, 10);
    mst.qtr = 63;
    wr3(8'hC8 ^ 8'h76, 8'hC8, 8'h00);
    wr3(8'hBE, 8'hC8, 8'h00);
    mst.qtr = 4;
    chk(half, 1'b1);
    span(20, 0);
    $display("test oscillator done");
    rst_b <= 1'b0;
    mst.wt(2);
    chk(fc, 8'h00);
    chk({aope, osc_run, obs}, 8'h00);
    rst_b <= 1'b1;
    mst.wt(30);
    $display("test second reset done");
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    print_verdict();
  end
endmodule
